// ===== rtl/svof_pkg.sv
package svof_pkg;

    // register offsets
    localparam logic [7:0] REG_OUT_CTRL  = 8'h1F;
    localparam logic [7:0] REG_CROP_HI   = 8'h25;
    localparam logic [7:0] REG_CROP_LO   = 8'h26;

    // reset values
    localparam logic [7:0] RST_OUT_CTRL  = 8'h00;
    localparam logic [7:0] RST_CROP_HI   = 8'h00;
    localparam logic [7:0] RST_CROP_LO   = 8'h00;
    localparam logic [7:0] RD_UNMAPPED   = 8'h00;

    // output_format_control fields
    localparam int         OC_MODE_MSB   = 2;
    localparam int         OC_SAVMOD     = 3;
    localparam int         OC_PARMOD     = 4;
    localparam int         OC_ANC        = 5;
    localparam int         OC_SWAP       = 6;
    localparam logic [7:0] OC_USED_MASK  = 8'h7F;

    // crop_start_lower_and_blank_gate fields
    localparam int         CL_START_MSB  = 1;
    localparam int         CL_GATE       = 2;
    localparam logic [7:0] CL_USED_MASK  = 8'h07;

    typedef enum logic [2:0] {
        SVOF_MODE_UNSC   = 3'b000,
        SVOF_MODE_SCL    = 3'b001,
        SVOF_MODE_SEP    = 3'b010,
        SVOF_MODE_MUX54  = 3'b011,
        SVOF_MODE_TOGGLE = 3'b100
    } svof_mode_t;

    // settings carried across to the pixel domain as one word
    typedef struct packed {
        logic [7:0] did_scl;
        logic [7:0] did_unsc;
        logic       gate;
        logic [9:0] start;
        logic [7:0] ctrl;
    } svof_cfg_t;

    // tagging packet bytes
    localparam logic [7:0] PKT_PRE0      = 8'h00;
    localparam logic [7:0] PKT_PRE1      = 8'hFF;
    localparam logic [1:0] PKT_DID_FIX   = 2'h1;
    localparam logic [7:0] PKT_SDID      = 8'h80;
    localparam logic [7:0] PKT_WC        = 8'h41;
    localparam logic [5:0] PKT_LINE_PAD  = 6'h00;
    localparam logic [7:0] PKT_DATA      = 8'h00;
    localparam logic [7:0] PKT_TT_SYNC   = 8'h27;
    localparam logic [7:0] PKT_FILL      = 8'h80;
    localparam logic [3:0] PKT_IDX_FIRST = 4'h0;
    localparam logic [3:0] PKT_IDX_DID   = 4'h3;
    localparam logic [3:0] PKT_IDX_SDID  = 4'h4;
    localparam logic [3:0] PKT_IDX_LINE  = 4'h6;
    localparam logic [3:0] PKT_IDX_LAST  = 4'hB;

    // default active-video window in pixel counts
    localparam logic [11:0] AV_DEF_START = 12'h200;
    localparam logic [11:0] AV_DEF_STOP  = 12'h700;

endpackage : svof_pkg

// ===== rtl/svof_formatter.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RQ1: three-bit mode picks unscaled, scaled, dual-clock mux, 54 MHz mux or field toggle.
// RQ2: sync modifier forces SAV/EAV MSB to one for unscaled, zero for scaled.
// RQ3: parity modifier clear folds that MSB into the protection bits.
// RQ4: ancillary enable inserts a packet tagging scaled or unscaled video.
// RQ5: host never enables this packet together with VBI ancillary output.
// RQ6: bit swap reverses the eight output lines.
// RQ7: packet opens with bytes 00, FF, FF.
// RQ8: data identifier carries inverse parity, even parity, fixed 0 1, identifier nibble.
// RQ9: identifier nibble from per-stream EAV setting, low nibble field 0, high field 1.
// RQ10: secondary identifier is 80, word count is 41.
// RQ11: bytes six and seven carry line number bits 7:0 and 9:8.
// RQ12: teletext puts sync pattern in byte eight and fill in byte nine.
// RQ13: checksum is eight-bit sum of identifier through last data byte.
// RQ14: fill bytes 80 pad the packet to a multiple of four.
// RQ15: upper start bits written first; new start applies on lower register write.
// RQ16: start value is a signed offset -512..511 from the default start.
// RQ17: control bit holds active-video window low during vertical blanking.
// RQ18: reserved bits read zero and do nothing.
module svof_formatter
    import svof_pkg::*;
(
    // system clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_arst_n,
    // register port
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    // identifier settings held elsewhere
    input  wire logic [7:0] i_eav_did_unsc,
    input  wire logic [7:0] i_eav_did_scl,
    // pixel clock
    input  wire logic       i_clk_pix,
    // unscaled stream
    input  wire logic [7:0] i_unsc_data,
    input  wire logic       i_unsc_xy,
    input  wire logic       i_unsc_anc_slot,
    // scaled stream
    input  wire logic [7:0] i_scl_data,
    input  wire logic       i_scl_xy,
    input  wire logic       i_scl_anc_slot,
    // line timing
    input  wire logic       i_field,
    input  wire logic [9:0] i_line_num,
    input  wire logic       i_vertical_blank_window,
    input  wire logic [10:0] i_pix_cnt,
    input  wire logic       i_teletext,
    // output port
    output logic      [7:0] o_data,
    output logic            o_clk1_qual,
    output logic            o_clk2_qual,
    output logic            o_active_video_window
);

    // ---------------- system domain registers ----------------
    logic [7:0] out_ctrl;
    logic [7:0] crop_hi;
    logic [7:0] crop_lo;
    logic [9:0] start_applied;

    wire        wr_oc  = i_reg_wr && (i_reg_addr == REG_OUT_CTRL);
    wire        wr_hi  = i_reg_wr && (i_reg_addr == REG_CROP_HI);
    wire        wr_lo  = i_reg_wr && (i_reg_addr == REG_CROP_LO);

    wire  [7:0] rd_mux = (i_reg_addr == REG_OUT_CTRL) ? out_ctrl :
                         (i_reg_addr == REG_CROP_HI)  ? crop_hi  :
                         (i_reg_addr == REG_CROP_LO)  ? crop_lo  : RD_UNMAPPED;

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            out_ctrl      <= RST_OUT_CTRL;
            crop_hi       <= RST_CROP_HI;
            crop_lo       <= RST_CROP_LO;
            start_applied <= {RST_CROP_HI, RST_CROP_LO[CL_START_MSB:0]};
            o_reg_rdata   <= RD_UNMAPPED;
        end else begin
            // RQ18 reserved bits dropped
            if (wr_oc) out_ctrl <= i_reg_wdata & OC_USED_MASK;
            if (wr_hi) crop_hi <= i_reg_wdata;
            if (wr_lo) crop_lo <= i_reg_wdata & CL_USED_MASK;
            // RQ15 commit on lower write
            if (wr_lo) start_applied <= {crop_hi, i_reg_wdata[CL_START_MSB:0]};
            if (i_reg_rd) o_reg_rdata <= rd_mux;
        end
    end

    // settings word handed over by a toggle handshake that reloads whenever idle
    svof_cfg_t cfg_now;
    svof_cfg_t xfer;
    logic      req;
    logic      ack_s1;
    logic      ack_s2;
    logic      ack;

    assign cfg_now = '{did_scl: i_eav_did_scl, did_unsc: i_eav_did_unsc,
                       gate: crop_lo[CL_GATE], start: start_applied, ctrl: out_ctrl};

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
            xfer   <= '0;
            req    <= 1'b0;
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
        end else begin
            ack_s1 <= ack;
            ack_s2 <= ack_s1;
            // xfer only moves while the pixel side is not sampling it
            if (ack_s2 == req) begin
                xfer <= cfg_now;
                req  <= ~req;
            end
        end
    end

    // ---------------- pixel domain ----------------
    svof_cfg_t  cfg_px;
    logic       req_s1;
    logic       req_s2;
    logic       req_s3;

    always_ff @(posedge i_clk_pix or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_px <= '0;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
            req_s3 <= 1'b0;
            ack    <= 1'b0;
        end else begin
            req_s1 <= req;
            req_s2 <= req_s1;
            req_s3 <= req_s2;
            if (req_s2 != req_s3) begin
                cfg_px <= xfer;
                ack    <= req_s2;
            end
        end
    end

    wire [2:0]  px_mode   = cfg_px.ctrl[OC_MODE_MSB:0];
    wire        px_savmod = cfg_px.ctrl[OC_SAVMOD];
    wire        px_parmod = cfg_px.ctrl[OC_PARMOD];
    wire        px_anc    = cfg_px.ctrl[OC_ANC];
    wire        px_swap   = cfg_px.ctrl[OC_SWAP];

    // RQ1 stream selection
    logic       phase;
    wire        is_mux    = (px_mode == SVOF_MODE_SEP) || (px_mode == SVOF_MODE_MUX54);
    wire        sel_scl   = (px_mode == SVOF_MODE_SCL) || (is_mux && phase) ||
                            ((px_mode == SVOF_MODE_TOGGLE) && i_field);
    wire [7:0]  st_data   = sel_scl ? i_scl_data : i_unsc_data;
    wire        st_xy     = sel_scl ? i_scl_xy : i_unsc_xy;
    wire        st_slot   = sel_scl ? i_scl_anc_slot : i_unsc_anc_slot;
    wire        next_clk1 = (px_mode != SVOF_MODE_SEP) || !sel_scl;
    wire        next_clk2 = (px_mode == SVOF_MODE_SEP) && sel_scl;

    // RQ2 MSB marks the stream
    wire        xy_msb    = ~sel_scl;
    wire        f_b       = st_data[6];
    wire        v_b       = st_data[5];
    wire        h_b       = st_data[4];
    wire [3:0]  xy_prot   = {v_b ^ h_b, f_b ^ h_b, f_b ^ v_b, f_b ^ v_b ^ h_b};
    // RQ3 fold MSB into parity
    wire [3:0]  xy_fold   = px_parmod ? xy_prot : (xy_prot ^ {4{xy_msb}});
    wire [7:0]  mod_byte  = (px_savmod && st_xy) ? {xy_msb, st_data[6:4], xy_fold} : st_data;

    // tagging packet state
    logic       pkt_active;
    logic [3:0] pkt_idx;
    logic [3:0] pkt_did;
    logic [9:0] pkt_line;
    logic       pkt_tt;

    // RQ4 start only when enabled; RQ5 host keeps VBI ancillary off meanwhile
    wire        pkt_start = st_slot && px_anc && !pkt_active;
    wire [7:0]  did_set   = sel_scl ? cfg_px.did_scl : cfg_px.did_unsc;
    // RQ9 nibble per field
    wire [3:0]  next_did  = i_field ? did_set[7:4] : did_set[3:0];

    always_ff @(posedge i_clk_pix or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pkt_active <= 1'b0;
            pkt_idx    <= PKT_IDX_FIRST;
            pkt_did    <= 4'h0;
            pkt_line   <= 10'h000;
            pkt_tt     <= 1'b0;
        end else if (pkt_start) begin
            pkt_active <= 1'b1;
            pkt_idx    <= PKT_IDX_FIRST;
            pkt_did    <= next_did;
            pkt_line   <= i_line_num;
            pkt_tt     <= i_teletext;
        end else if (pkt_active) begin
            pkt_active <= (pkt_idx != PKT_IDX_LAST);
            pkt_idx    <= pkt_idx + 4'h1;
        end
    end

    logic [7:0] pkt_byte [0:11];
    wire        did_ep = ^{PKT_DID_FIX, pkt_did};

    // RQ7 preamble
    assign pkt_byte[0]  = PKT_PRE0;
    assign pkt_byte[1]  = PKT_PRE1;
    assign pkt_byte[2]  = PKT_PRE1;
    // RQ8 identifier with parity
    assign pkt_byte[3]  = {~did_ep, did_ep, PKT_DID_FIX, pkt_did};
    // RQ10 fixed identifier and count
    assign pkt_byte[4]  = PKT_SDID;
    assign pkt_byte[5]  = PKT_WC;
    // RQ11 line number
    assign pkt_byte[6]  = pkt_line[7:0];
    assign pkt_byte[7]  = {PKT_LINE_PAD, pkt_line[9:8]};
    // RQ12 teletext sync and fill
    assign pkt_byte[8]  = pkt_tt ? PKT_TT_SYNC : PKT_DATA;
    assign pkt_byte[9]  = pkt_tt ? PKT_FILL : PKT_DATA;
    // RQ13 checksum wraps at eight bits
    assign pkt_byte[10] = pkt_byte[3] + pkt_byte[4] + pkt_byte[5] + pkt_byte[6] +
                          pkt_byte[7] + pkt_byte[8] + pkt_byte[9];
    // RQ14 pad to twelve bytes
    assign pkt_byte[11] = PKT_FILL;

    // packet replaces both streams while it runs, also in the mux modes
    wire [7:0]  sel_byte = pkt_active ? pkt_byte[pkt_idx] : mod_byte;
    wire [7:0]  next_data;
    // reversed copies for the checks, since a stream operator cannot sit in a compare
    wire [7:0]  unsc_rev;
    wire [7:0]  out_rev;

    // RQ6 bit order swap
    genvar b;
    for (b = 0; b < 8; b++) begin : g_swap
        assign next_data[b] = px_swap ? sel_byte[7 - b] : sel_byte[b];
        assign unsc_rev[b]  = i_unsc_data[7 - b];
        assign out_rev[b]   = o_data[7 - b];
    end
    wire [7:0]  out_plain = px_swap ? out_rev : o_data;

    // RQ16 signed offset from default start
    wire [11:0] start_pos = AV_DEF_START + {{2{cfg_px.start[9]}}, cfg_px.start};
    wire        in_win    = ({1'b0, i_pix_cnt} >= start_pos) && ({1'b0, i_pix_cnt} < AV_DEF_STOP);
    // RQ17 blanking gate
    wire        next_avw  = in_win && !(cfg_px.gate && i_vertical_blank_window);

    always_ff @(posedge i_clk_pix or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase                 <= 1'b0;
            o_data                <= 8'h00;
            o_clk1_qual           <= 1'b0;
            o_clk2_qual           <= 1'b0;
            o_active_video_window <= 1'b0;
        end else begin
            phase                 <= ~phase;
            o_data                <= next_data;
            o_clk1_qual           <= next_clk1;
            o_clk2_qual           <= next_clk2;
            o_active_video_window <= next_avw;
        end
    end

    // ---------------- checks ----------------
    AST_START_ON_LSB: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ15
        $changed(start_applied) |-> $past(wr_lo))
        else $error("start changed without lower register write");

    AST_RESERVED_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_arst_n) // RQ18
        (i_reg_rd && i_reg_addr == REG_CROP_LO) |=> (o_reg_rdata & ~CL_USED_MASK) == 8'h00)
        else $error("reserved bits read nonzero");

    AST_UNSC_PASS: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ1
        (px_mode == SVOF_MODE_UNSC && !pkt_active && !i_unsc_xy && !px_swap && !pkt_start)
        |=> o_data == $past(i_unsc_data))
        else $error("unscaled data not passed in mode 0");

    AST_SAV_MSB: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ2
        (px_mode == SVOF_MODE_SCL && px_savmod && i_scl_xy && !pkt_active && !px_swap)
        |=> !o_data[7])
        else $error("scaled sync MSB not cleared");

    AST_SWAP: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ6
        (px_mode == SVOF_MODE_UNSC && !pkt_active && !i_unsc_xy && px_swap && !pkt_start)
        |=> o_data == $past(unsc_rev))
        else $error("bit swap order wrong");

    AST_SEP_CLK2: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ1
        (px_mode == SVOF_MODE_SEP && phase) |=> (o_clk2_qual && !o_clk1_qual))
        else $error("scaled byte not on clock 2 in mode 2");

    AST_UNSC_MSB: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ2
        (px_mode == SVOF_MODE_UNSC && px_savmod && i_unsc_xy && !pkt_active && !px_swap)
        |=> o_data[7])
        else $error("unscaled sync MSB not set");

    AST_ANC_OFF: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ4
        (st_slot && !px_anc && !pkt_active) |=> !pkt_active)
        else $error("packet started with ancillary disabled");

    AST_TT_BYTES: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ12
        (pkt_active && pkt_idx == PKT_IDX_LINE && pkt_tt)
        |=> ##2 out_plain == PKT_TT_SYNC ##1 out_plain == PKT_FILL)
        else $error("teletext sync or fill byte wrong");

    AST_PREAMBLE: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ7
        $rose(pkt_active) |=> o_data == PKT_PRE0 ##1 o_data == PKT_PRE1 ##1 o_data == PKT_PRE1)
        else $error("packet preamble wrong");

    AST_DID_PARITY: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ8
        (pkt_active && pkt_idx == PKT_IDX_DID && !px_swap)
        |=> (o_data[7] != o_data[6]) && (o_data[6] == ^o_data[5:0]))
        else $error("identifier parity wrong");

    AST_SDID_WC: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ10
        (pkt_active && pkt_idx == PKT_IDX_SDID && !px_swap)
        |=> o_data == PKT_SDID ##1 o_data == PKT_WC)
        else $error("secondary id or word count wrong");

    AST_LINE: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ11
        (pkt_active && pkt_idx == PKT_IDX_LINE && !px_swap)
        |=> o_data == pkt_line[7:0] ##1 o_data == {PKT_LINE_PAD, pkt_line[9:8]})
        else $error("line number bytes wrong");

    AST_FILL_END: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ14
        (pkt_active && pkt_idx == PKT_IDX_LAST && !px_swap) |=> o_data == PKT_FILL ##0 !pkt_active)
        else $error("final fill byte wrong");

    AST_VBLANK_GATE: assert property (@(posedge i_clk_pix) disable iff (!i_arst_n) // RQ17
        (cfg_px.gate && i_vertical_blank_window) |=> !o_active_video_window)
        else $error("window active in blanking");

    COV_MUX54: cover property (@(posedge i_clk_pix) disable iff (!i_arst_n)
        px_mode == SVOF_MODE_MUX54 && phase ##1 px_mode == SVOF_MODE_MUX54);
    COV_SEP_CLK2: cover property (@(posedge i_clk_pix) disable iff (!i_arst_n) o_clk2_qual);
    COV_PACKET: cover property (@(posedge i_clk_pix) disable iff (!i_arst_n)
        pkt_active && pkt_idx == PKT_IDX_LAST);
    COV_COMMIT: cover property (@(posedge i_clk_sys) disable iff (!i_arst_n) wr_hi ##[1:4] wr_lo);

endmodule : svof_formatter

`default_nettype wire

// ===== tb/svof_rx_model.sv
`timescale 1ns/1ps
`default_nettype none

module svof_rx_model
    import svof_pkg::*;
(
    // pixel side of the link
    input  wire logic        i_clk_pix,
    input  wire logic        i_swapped,
    input  wire logic [7:0]  i_data,
    // last twelve bytes, newest in the low byte
    output logic      [95:0] o_win
);
    logic [7:0] rx_byte;

    always_comb begin
        for (int k = 0; k < 8; k++) begin
            rx_byte[k] = i_swapped ? i_data[7 - k] : i_data[k];
        end
    end

    // sampled on the same edge as the sender launches, so one byte per pixel clock
    always_ff @(posedge i_clk_pix) begin
        o_win <= {o_win[87:0], rx_byte};
    end
endmodule : svof_rx_model

`default_nettype wire

// ===== tb/svof_formatter_tb.sv
`timescale 1ns/1ps
`default_nettype none

module svof_formatter_tb
    import svof_pkg::*;
;
    localparam int LIMIT = 40000;
    logic        i_clk_sys, i_arst_n, i_reg_wr, i_reg_rd, i_clk_pix, rx_swap;
    logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata, i_eav_did_unsc, i_eav_did_scl;
    logic [7:0]  i_unsc_data, i_scl_data, o_data;
    logic        i_unsc_xy, i_unsc_anc_slot, i_scl_xy, i_scl_anc_slot, i_field, i_teletext;
    logic        i_vertical_blank_window, o_clk1_qual, o_clk2_qual, o_active_video_window;
    logic [9:0]  i_line_num;
    logic [10:0] i_pix_cnt;
    logic [95:0] rx_win;
    int          error_cnt, n_tests, cyc;

    svof_formatter DUT (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .i_eav_did_unsc(i_eav_did_unsc), .i_eav_did_scl(i_eav_did_scl), .i_clk_pix(i_clk_pix),
        .i_unsc_data(i_unsc_data), .i_unsc_xy(i_unsc_xy), .i_unsc_anc_slot(i_unsc_anc_slot),
        .i_scl_data(i_scl_data), .i_scl_xy(i_scl_xy), .i_scl_anc_slot(i_scl_anc_slot), .i_field(i_field),
        .i_line_num(i_line_num), .i_vertical_blank_window(i_vertical_blank_window), .i_pix_cnt(i_pix_cnt),
        .i_teletext(i_teletext), .o_data(o_data), .o_clk1_qual(o_clk1_qual), .o_clk2_qual(o_clk2_qual),
        .o_active_video_window(o_active_video_window));

    svof_rx_model u_rx (.i_clk_pix(i_clk_pix), .i_swapped(rx_swap), .i_data(o_data), .o_win(rx_win));

    always #5 i_clk_sys = ~i_clk_sys;
    // odd offset keeps the two clocks from ever sharing an edge
    initial begin
        #3;
        forever #80 i_clk_pix = ~i_clk_pix;
    end

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic pix(input int n);
        repeat (n) @(posedge i_clk_pix);
    endtask : pix

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk_sys);
        i_reg_rd   <= 1'b0;
        @(negedge i_clk_sys);
        check(o_reg_rdata, exp);
    endtask : reg_rd

    task automatic cfg(input logic [7:0] c);
        reg_wr(REG_OUT_CTRL, c);
        pix(12);
    endtask : cfg

    task automatic slot(input logic scl);
        @(posedge i_clk_pix);
        i_scl_anc_slot  <= scl;
        i_unsc_anc_slot <= ~scl;
        @(posedge i_clk_pix);
        i_scl_anc_slot  <= 1'b0;
        i_unsc_anc_slot <= 1'b0;
    endtask : slot

    task automatic t_regs();
        reg_rd(REG_OUT_CTRL, RST_OUT_CTRL);
        reg_rd(REG_CROP_HI, RST_CROP_HI);
        reg_rd(REG_CROP_LO, RST_CROP_LO);
        reg_wr(REG_OUT_CTRL, 8'hFF);
        reg_wr(REG_CROP_LO, 8'hFF);
        reg_wr(8'h40, 8'h00);
        reg_rd(REG_OUT_CTRL, 8'h7F);
        reg_rd(REG_CROP_LO, 8'h07);
        reg_rd(8'h40, RD_UNMAPPED);
        reg_wr(REG_CROP_LO, 8'h00);
    endtask : t_regs

    task automatic t_modes();
        logic [7:0] a;
        logic [7:0] b;
        for (int m = 0; m < 6; m++) begin
            cfg(8'(m));
            @(negedge i_clk_pix);
            a = o_data;
            @(negedge i_clk_pix);
            b = o_data;
            if (m == 2 || m == 3) check(a ^ b, 8'h12 ^ 8'hC4);
            else check(b, (m == 1) ? 8'hC4 : 8'h12);
            check({6'h00, o_clk1_qual, o_clk2_qual}, (m == 2 && b == 8'hC4) ? 8'h01 : 8'h02);
        end
        cfg(8'h04);
        @(posedge i_clk_pix);
        i_field <= 1'b1;
        pix(2);
        @(negedge i_clk_pix);
        check(o_data, 8'hC4);
        cfg(8'h40);
        @(negedge i_clk_pix);
        check(o_data, 8'h48);
        cfg(8'h00);
        slot(1'b0);
        pix(3);
        @(negedge i_clk_pix);
        check(o_data, 8'h12);
    endtask : t_modes

    task automatic t_xy();
        logic [23:0] tab [5] = '{24'h00_1D_1D, 24'h18_1D_9D, 24'h08_1D_92, 24'h09_9D_1D, 24'h19_9D_1D};
        for (int k = 0; k < 5; k++) begin
            cfg(tab[k][23:16]);
            @(posedge i_clk_pix);
            i_unsc_xy   <= 1'b1;
            i_scl_xy    <= 1'b1;
            i_unsc_data <= tab[k][15:8];
            i_scl_data  <= tab[k][15:8];
            pix(1);
            @(negedge i_clk_pix);
            check(o_data, tab[k][7:0]);
        end
        @(posedge i_clk_pix);
        i_unsc_xy   <= 1'b0;
        i_scl_xy    <= 1'b0;
        i_unsc_data <= 8'h12;
        i_scl_data  <= 8'hC4;
    endtask : t_xy

    task automatic t_packet(input logic scl, input logic fld, input logic tt, input logic [9:0] line);
        logic [7:0] src;
        logic [5:0] low6;
        logic [7:0] exp [12];
        src  = scl ? i_eav_did_scl : i_eav_did_unsc;
        low6 = {2'b01, fld ? src[7:4] : src[3:0]};
        exp  = '{8'h00, 8'hFF, 8'hFF, {~^low6, ^low6, low6}, 8'h80, 8'h41, line[7:0], {6'h00, line[9:8]},
                 tt ? PKT_TT_SYNC : 8'h00, tt ? 8'h80 : 8'h00, 8'h00, 8'h80};
        for (int i = 3; i < 10; i++) exp[10] += exp[i];
        rx_swap = fld;
        cfg({1'b0, fld, 1'b1, 4'h0, scl});
        @(posedge i_clk_pix);
        i_field    <= fld;
        i_line_num <= line;
        i_teletext <= tt;
        slot(scl);
        pix(13);
        @(negedge i_clk_pix);
        for (int i = 0; i < 12; i++) check(rx_win[95 - 8 * i -: 8], exp[i]);
    endtask : t_packet

    task automatic win_at(input logic [10:0] cnt, input logic vb, input logic e);
        @(posedge i_clk_pix);
        i_pix_cnt               <= cnt;
        i_vertical_blank_window <= vb;
        pix(1);
        @(negedge i_clk_pix);
        check({7'h00, o_active_video_window}, {7'h00, e});
    endtask : win_at

    task automatic t_window();
        win_at(11'h200, 1'b0, 1'b1);
        reg_wr(REG_CROP_HI, 8'h01);
        pix(12);
        win_at(11'h200, 1'b0, 1'b1);
        reg_wr(REG_CROP_LO, 8'h07);
        pix(12);
        win_at(11'h206, 1'b0, 1'b0);
        win_at(11'h207, 1'b0, 1'b1);
        win_at(11'h207, 1'b1, 1'b0);
        win_at(11'h700, 1'b0, 1'b0);
        reg_wr(REG_CROP_HI, 8'hFF);
        reg_wr(REG_CROP_LO, 8'h03);
        pix(12);
        win_at(11'h1FE, 1'b0, 1'b0);
        win_at(11'h1FF, 1'b1, 1'b1);
    endtask : t_window

    initial begin
        {i_clk_sys, i_clk_pix, i_arst_n, i_reg_wr, i_reg_rd, rx_swap} = '0;
        {i_unsc_xy, i_scl_xy, i_unsc_anc_slot, i_scl_anc_slot, i_field, i_teletext} = '0;
        {i_reg_addr, i_reg_wdata, i_line_num, i_pix_cnt, i_vertical_blank_window} = '0;
        {error_cnt, n_tests, cyc} = '0;
        i_eav_did_unsc = 8'hB7;
        i_eav_did_scl  = 8'h6C;
        i_unsc_data    = 8'h12;
        i_scl_data     = 8'hC4;
        // held in pixel clocks so both domains see several edges in reset
        repeat (6) @(posedge i_clk_pix);
        i_arst_n <= 1'b1;
        t_regs();
        t_modes();
        t_xy();
        t_packet(1'b0, 1'b0, 1'b0, 10'h2C5);
        t_packet(1'b1, 1'b1, 1'b1, 10'h13A);
        t_window();
        end_of_test();
    end
endmodule : svof_formatter_tb

`default_nettype wire
